// ---- bench/sds_slave_model.sv ----
// far-side spi slave model: mode 0, msb first, reply byte resent for every byte of a frame
module sds_slave_model (
  input  wire logic       sck,
  input  wire logic       ssel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic      [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_reg;
  int         n;
  initial miso = 1'b0;
  // select edge loads the reply; a released line shows the inverse, never a stale bit
  always @(ssel_n)
  begin
    n = 0;
    sh_reg = reply;
    miso = ssel_n ? ~miso : reply[7];
  end
  // capture on the rising clock
  always @(posedge sck)
  begin
    got = {got[6:0], mosi};
    n = n + 1;
  end
  // change on the falling clock, reload after each byte
  always @(negedge sck)
  begin
    sh_reg = (n == 8) ? reply : {sh_reg[6:0], 1'b0};
    n = n % 8;
    miso = sh_reg[7];
  end
endmodule // sds_slave_model

// ---- bench/spi_delay_and_status_test.sv ----
// self-checking bench: master delays, status flags, interrupt, slave errors
module spi_delay_and_status_test import sds_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, wr, rd, sck_i, ssel_n_i, mosi, sck, ssel_n, moe, sdo, sdo_oe;
  logic        irq, miso;
  logic [31:0] addr, wdata, rdata, v;
  logic [7:0]  got, reply, s;
  int          num_errors, comparisons, cyc, ss_fall, ss_rise, ss_cnt;
  int          rises[$];

  sds_spi_core u_dut (
    .clk(clk), .reset(reset), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr),
    .bus_rd(rd), .bus_rdata(rdata), .spi_sck_in(sck_i), .spi_ssel_n_in(ssel_n_i),
    .spi_sdi(moe ? miso : mosi), .spi_sck_out(sck), .spi_ssel_n_out(ssel_n),
    .spi_mst_oe(moe), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .irq(irq));
  sds_slave_model u_far (.sck(sck), .ssel_n(ssel_n), .mosi(sdo), .reply(reply),
    .miso(miso), .got(got));

  // ----------------------------------------
  // clock, timeout and link time stamps
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cycle ceiling cuts a hung sequence short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  // stamps in clock cycles; time based so no race with the clock edge
  always @(negedge ssel_n) ss_fall = int'($time / 10);
  always @(posedge ssel_n)
  begin
    ss_rise = int'($time / 10);
    ss_cnt++;
  end
  always @(posedge sck) rises.push_back(int'($time / 10));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic expect_reg(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, e);
  endtask
  task automatic wait_ssel(input logic l);
    for (int k = 0; k < 2000 && ssel_n !== l; k++) @(posedge clk);
    check(32'(ssel_n), 32'(l));
  endtask
  task automatic wait_sck(input int n);
    for (int k = 0; k < 3000 && rises.size() < n; k++) @(posedge clk);
  endtask
  // one mode 0 character as far-side master, 160 ns clock
  task automatic slave_byte(input logic [7:0] b, output logic [7:0] o);
    for (int i = 7; i >= 0; i--)
    begin
      mosi <= b[i];
      repeat (8) @(posedge clk);
      sck_i <= 1'b1;
      repeat (8) @(posedge clk);
      o[i] = sdo;
      sck_i <= 1'b0;
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    expect_reg(SDS_DLY_ADDR, 32'h0);
    expect_reg(SDS_STAT_ADDR, 32'h2);
    wr_reg(SDS_DLY_ADDR, 32'h1132);
    expect_reg(SDS_DLY_ADDR, 32'h1132);
    expect_reg(32'h4005_8030, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_single();
    wr_reg(SDS_MASK_ADDR, 32'h30);
    wr_reg(SDS_CTRL_ADDR, 32'h3);
    wr_reg(SDS_TXCTL_ADDR, 32'h1a5);
    wait_ssel(1'b0);
    check(32'(moe), 32'h1);
    check(32'(sdo_oe), 32'h1);
    wait_ssel(1'b1);
    check(32'(rises[0] - ss_fall), 32'd56);
    check(32'(ss_rise - ss_fall), 32'd224);
    check(32'(got), 32'ha5);
    expect_reg(SDS_STAT_ADDR, 32'h33);
    check(32'(irq), 32'h1);
    expect_reg(SDS_RX_DATA_REG_ADDR, 32'h96);
    wr_reg(SDS_STAT_ADDR, 32'h0);
    expect_reg(SDS_STAT_ADDR, 32'h32);
    wr_reg(SDS_STAT_ADDR, 32'h30);
    expect_reg(SDS_STAT_ADDR, 32'h02);
    check(32'(irq), 32'h0);
    $display("test single done");
  endtask
  task automatic t_back();
    rises.delete();
    wr_reg(SDS_TXCTL_ADDR, 32'h1a5);
    wait_sck(1);
    wr_reg(SDS_TXCTL_ADDR, 32'h15a);
    wait_ssel(1'b1);
    expect_reg(SDS_RX_DATA_REG_ADDR, 32'h96);
    wait_ssel(1'b0);
    check(32'(ss_fall - ss_rise >= 32 && ss_fall - ss_rise <= 48), 32'h1);
    wait_ssel(1'b1);
    check(32'(got), 32'h5a);
    expect_reg(SDS_RX_DATA_REG_ADDR, 32'h96);
    $display("test back to back done");
  endtask
  task automatic t_frames();
    wr_reg(SDS_STAT_ADDR, 32'h30);
    rises.delete();
    ss_cnt = 0;
    wr_reg(SDS_TX_DATA_REG_ADDR, 32'h11);
    wait_sck(1);
    wr_reg(SDS_TXCTL_ADDR, 32'h1c3);
    wait_sck(8);
    repeat (40) @(posedge clk);
    expect_reg(SDS_STAT_ADDR, 32'h51);
    check(32'(got), 32'h11);
    expect_reg(SDS_RX_DATA_REG_ADDR, 32'h96);
    wait_ssel(1'b1);
    check(32'(rises[8] - rises[7] >= 32), 32'h1);
    check(32'(ss_cnt), 32'h1);
    expect_reg(SDS_STAT_ADDR, 32'h33);
    expect_reg(SDS_RX_DATA_REG_ADDR, 32'h96);
    $display("test frames done");
  endtask
  task automatic t_slave();
    wr_reg(SDS_CTRL_ADDR, 32'h0);
    wr_reg(SDS_CTRL_ADDR, 32'h1);
    wr_reg(SDS_STAT_ADDR, 32'h3c);
    wr_reg(SDS_MASK_ADDR, 32'h0c);
    wr_reg(SDS_TX_DATA_REG_ADDR, 32'h3c);
    ssel_n_i <= 1'b0;
    slave_byte(8'h5a, s);
    check(32'(s), 32'h3c);
    expect_reg(SDS_STAT_ADDR, 32'h13);
    check(32'(irq), 32'h0);
    slave_byte(8'ha5, s);
    ssel_n_i <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
    check(32'(sdo_oe), 32'h0);
    check(32'(moe), 32'h0);
    expect_reg(SDS_STAT_ADDR, 32'h3f);
    check(32'(irq), 32'h1);
    expect_reg(SDS_RX_DATA_REG_ADDR, 32'h5a);
    wr_reg(SDS_STAT_ADDR, 32'h3c);
    expect_reg(SDS_STAT_ADDR, 32'h02);
    check(32'(irq), 32'h0);
    wr_reg(SDS_CTRL_ADDR, 32'h0);
    $display("test slave done");
  endtask

  // main sequence
  initial
  begin
    {wr, rd, sck_i, mosi} = '0;
    reset = 1'b1;
    ssel_n_i = 1'b1;
    addr = '0;
    wdata = '0;
    reply = 8'h96;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_single();
    t_back();
    t_frames();
    t_slave();
    report_and_stop();
  end
endmodule // spi_delay_and_status_test

// ---- src/sds_pkg.sv ----
// package: register map, field layout, reset values and states of the spi delay/status block
package sds_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] SDS_CTRL_ADDR  = 32'h4005_8000;
  localparam logic [31:0] SDS_DLY_ADDR   = 32'h4005_8004;
  localparam logic [31:0] SDS_STAT_ADDR  = 32'h4005_8008;
  localparam logic [31:0] SDS_MASK_ADDR  = 32'h4005_800c;
  localparam logic [31:0] SDS_RX_DATA_REG_ADDR = 32'h4005_8014;
  localparam logic [31:0] SDS_TXCTL_ADDR = 32'h4005_8018;
  localparam logic [31:0] SDS_TX_DATA_REG_ADDR = 32'h4005_801c;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int SDS_FLD_W    = 4;
  localparam int SDS_PRE_LSB  = 0;
  localparam int SDS_POST_LSB = 4;
  localparam int SDS_FDLY_LSB = 8;
  localparam int SDS_XDLY_LSB = 12;
  localparam int SDS_DLY_W    = 16;
  localparam int SDS_CTRL_EN  = 0;
  localparam int SDS_CTRL_MST = 1;
  localparam int SDS_CTRL_W   = 2;
  localparam int SDS_EOT_BIT  = 8;
  localparam int SDS_DATA_W   = 8;
  localparam int SDS_ST_RX    = 0;
  localparam int SDS_ST_TX    = 1;
  localparam int SDS_ST_OVR   = 2;
  localparam int SDS_ST_UNDR  = 3;
  localparam int SDS_ST_SSA   = 4;
  localparam int SDS_ST_SSD   = 5;
  localparam int SDS_ST_STALL = 6;
  localparam int SDS_STAT_W   = 7;
  localparam int SDS_STICKY_W = 4;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [SDS_DLY_W-1:0]  SDS_DLY_RST  = 16'h0000;
  localparam logic [SDS_CTRL_W-1:0] SDS_CTRL_RST = 2'h0;
  localparam logic [SDS_STAT_W-1:0] SDS_MASK_RST = 7'h00;
  localparam logic [2:0]            SDS_LAST_BIT = 3'h7;
  localparam int SDS_CLK_NS     = 10;
  localparam int SDS_SPI_CLK_NS = 160;
  localparam int SDS_SPI_DIV    = SDS_SPI_CLK_NS / SDS_CLK_NS;

  // master sequencer states
  typedef enum logic [2:0] {
    SDS_IDLE, SDS_LEAD, SDS_PRE, SDS_FRAME, SDS_FDLY, SDS_STALL, SDS_POST, SDS_XDLY
  } sds_state_t;

endpackage

// ---- src/sds_spi_core.sv ----
// spi controller core: master delays, slave engine and status flags
module sds_spi_core
  import sds_pkg::*;
#(
  parameter int DIV = sds_pkg::SDS_SPI_DIV
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic        spi_sck_in,
  input  wire logic        spi_ssel_n_in,
  input  wire logic        spi_sdi,
  output logic             spi_sck_out,
  output logic             spi_ssel_n_out,
  output logic             spi_mst_oe,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  output logic             irq
);
  import sds_pkg::*;

  // ----------------------------------------------------------------
  // registers and internal state
  // ----------------------------------------------------------------
  logic [SDS_CTRL_W-1:0]   ctrl_reg;
  logic [SDS_DLY_W-1:0]    dly_reg;
  logic [SDS_STAT_W-1:0]   mask_reg;
  logic [SDS_STICKY_W-1:0] sticky_reg;
  logic [SDS_DATA_W-1:0]   hold_reg;
  logic                    hold_eot_reg;
  logic                    hold_full_reg;
  logic [SDS_DATA_W-1:0]   rx_buf_reg;
  logic                    rx_full_reg;
  logic [SDS_DATA_W-1:0]   rx_sh_reg;
  logic [SDS_DATA_W-1:0]   tx_sh_reg;
  logic [SDS_DATA_W-1:0]   slv_tx_reg;
  logic                    eot_reg;
  logic [2:0]              bit_reg;
  logic [2:0]              slv_bit_reg;
  logic                    disc_reg;
  logic [SDS_FLD_W-1:0]    cnt_reg;
  logic                    stall_reg;
  logic                    sel_prev_reg;
  logic                    sck_prev_reg;
  sds_state_t              st_reg;
  logic                    tick;
  logic                    half;
  logic                    sck_s;
  logic                    ssel_n_s;
  logic                    sdi_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  sds_tick #(.DIV(DIV)) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .half  (half)
  );

  sds_sync #(.W(3), .RST(3'h2)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({spi_sck_in, spi_ssel_n_in, spi_sdi}),
    .q     ({sck_s, ssel_n_s, sdi_s})
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic en       = ctrl_reg[SDS_CTRL_EN];
  wire logic mst      = en && ctrl_reg[SDS_CTRL_MST];
  wire logic wr_stat  = bus_wr && (bus_addr == SDS_STAT_ADDR);
  wire logic wr_tx    = bus_wr && ((bus_addr == SDS_TX_DATA_REG_ADDR) || (bus_addr == SDS_TXCTL_ADDR));
  wire logic rd_rx    = bus_rd && (bus_addr == SDS_RX_DATA_REG_ADDR);
  wire logic [SDS_FLD_W-1:0] pre_f  = dly_reg[SDS_PRE_LSB +: SDS_FLD_W];
  wire logic [SDS_FLD_W-1:0] post_f = dly_reg[SDS_POST_LSB +: SDS_FLD_W];
  wire logic [SDS_FLD_W-1:0] fdly_f = dly_reg[SDS_FDLY_LSB +: SDS_FLD_W];
  wire logic [SDS_FLD_W-1:0] xdly_f = dly_reg[SDS_XDLY_LSB +: SDS_FLD_W];

  // slave pin events, read from the second sync stage only
  wire logic slv_act  = en && !mst && !ssel_n_s;
  wire logic rise     = slv_act && sck_s && !sck_prev_reg;
  wire logic fall     = slv_act && !sck_s && sck_prev_reg;
  wire logic first    = rise && (slv_bit_reg == 3'h0);
  wire logic ovr_set  = first && rx_full_reg;
  wire logic undr_set = first && !hold_full_reg;

  // master and slave frame boundaries
  wire logic mst_done = (st_reg == SDS_FRAME) && tick && (bit_reg == SDS_LAST_BIT);
  wire logic slv_done = rise && (slv_bit_reg == SDS_LAST_BIT) && !disc_reg;
  wire logic rx_load  = mst_done || slv_done;
  // master never starts a frame that could overrun its receiver
  wire logic can_go   = hold_full_reg && !rx_full_reg && !rx_load;
  wire logic go_frame = tick && (((st_reg == SDS_LEAD) && (pre_f == '0)) ||
                        ((st_reg == SDS_PRE) && (cnt_reg == '0)) ||
                        ((st_reg == SDS_FDLY) && (cnt_reg == '0)) ||
                        (st_reg == SDS_STALL) ||
                        (mst_done && !eot_reg && (fdly_f == '0)));
  wire logic mst_start = go_frame && can_go;

  // select edge detection, master or slave view
  wire logic sel_now = mst ? !spi_ssel_n_out : (en && !ssel_n_s);
  wire logic ssa_set = sel_now && !sel_prev_reg;
  wire logic ssd_set = !sel_now && sel_prev_reg;

  wire logic [SDS_STAT_W-1:0] stat_v = {stall_reg, sticky_reg, !hold_full_reg, rx_full_reg};

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // control, delay and mask; upper delay bits are not stored
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg <= SDS_CTRL_RST;
      dly_reg  <= SDS_DLY_RST;
      mask_reg <= SDS_MASK_RST;
    end
    else if (bus_wr)
    begin
      case (bus_addr)
        SDS_CTRL_ADDR: ctrl_reg <= bus_wdata[SDS_CTRL_W-1:0];
        SDS_DLY_ADDR:  dly_reg  <= bus_wdata[SDS_DLY_W-1:0];
        SDS_MASK_ADDR: mask_reg <= bus_wdata[SDS_STAT_W-1:0];
        default:       ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bus_rdata <= '0;
    else if (bus_rd)
    begin
      case (bus_addr)
        SDS_CTRL_ADDR:  bus_rdata <= 32'(ctrl_reg);
        SDS_DLY_ADDR:   bus_rdata <= 32'(dly_reg);
        SDS_STAT_ADDR:  bus_rdata <= 32'(stat_v);
        SDS_MASK_ADDR:  bus_rdata <= 32'(mask_reg);
        SDS_RX_DATA_REG_ADDR: bus_rdata <= 32'(rx_buf_reg);
        default:        bus_rdata <= '0;
      endcase
    end
    else
      bus_rdata <= '0;
  end

  // write-one-to-clear, a new event wins over the clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sticky_reg <= '0;
    else
      sticky_reg <= (sticky_reg & ~(wr_stat ? bus_wdata[SDS_ST_SSD:SDS_ST_OVR] : 4'h0)) |
                    {ssd_set, ssa_set, undr_set, ovr_set};
  end

  // level interrupt from unmasked status
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(stat_v & mask_reg);
  end

  // ----------------------------------------------------------------
  // data buffers
  // ----------------------------------------------------------------
  // holding register: write clears tx ready, move sets it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hold_reg      <= '0;
      hold_eot_reg  <= 1'b0;
      hold_full_reg <= 1'b0;
    end
    else if (!en)
      hold_full_reg <= 1'b0;
    else if (wr_tx)
    begin
      hold_reg      <= bus_wdata[SDS_DATA_W-1:0];
      hold_eot_reg  <= (bus_addr == SDS_TXCTL_ADDR) && bus_wdata[SDS_EOT_BIT];
      hold_full_reg <= 1'b1;
    end
    else if (mst_start || (first && hold_full_reg))
      hold_full_reg <= 1'b0;
  end

  // receive buffer, load wins over a read in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_buf_reg  <= '0;
      rx_full_reg <= 1'b0;
    end
    else if (!en)
      rx_full_reg <= 1'b0;
    else if (rx_load)
    begin
      rx_buf_reg  <= mst_done ? rx_sh_reg : {rx_sh_reg[SDS_DATA_W-2:0], sdi_s};
      rx_full_reg <= 1'b1;
    end
    else if (rd_rx)
      rx_full_reg <= 1'b0;
  end

  // receive shifter: master samples mid-period, slave on rising sck
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rx_sh_reg <= '0;
    else if (((st_reg == SDS_FRAME) && half) || rise)
      rx_sh_reg <= {rx_sh_reg[SDS_DATA_W-2:0], sdi_s};
  end

  // ----------------------------------------------------------------
  // master sequencer
  // ----------------------------------------------------------------
  // runs only in master mode, steps on period ticks
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg         <= SDS_IDLE;
      cnt_reg        <= '0;
      bit_reg        <= '0;
      eot_reg        <= 1'b0;
      tx_sh_reg      <= '0;
      spi_ssel_n_out <= 1'b1;
    end
    else if (!mst)
    begin
      st_reg         <= SDS_IDLE;
      spi_ssel_n_out <= 1'b1;
    end
    else if (mst_start)
    begin
      st_reg    <= SDS_FRAME;
      bit_reg   <= '0;
      eot_reg   <= hold_eot_reg;
      tx_sh_reg <= hold_reg;
    end
    else if (go_frame)
      st_reg <= SDS_STALL;
    else if (tick)
    begin
      case (st_reg)
        SDS_IDLE:
          if (hold_full_reg)
          begin
            st_reg         <= SDS_LEAD;
            spi_ssel_n_out <= 1'b0;
          end
        SDS_LEAD:
        begin
          st_reg  <= SDS_PRE;
          cnt_reg <= SDS_FLD_W'(pre_f - 1'b1);
        end
        SDS_FRAME:
          if (bit_reg != SDS_LAST_BIT)
          begin
            bit_reg   <= 3'(bit_reg + 1'b1);
            tx_sh_reg <= {tx_sh_reg[SDS_DATA_W-2:0], 1'b0};
          end
          else if (!eot_reg)
          begin
            // frame delay only with select held
            st_reg  <= SDS_FDLY;
            cnt_reg <= SDS_FLD_W'(fdly_f - 1'b1);
          end
          else if (post_f != '0)
          begin
            st_reg  <= SDS_POST;
            cnt_reg <= SDS_FLD_W'(post_f - 1'b1);
          end
          else
          begin
            st_reg         <= SDS_XDLY;
            cnt_reg        <= xdly_f;
            spi_ssel_n_out <= 1'b1;
          end
        SDS_PRE, SDS_FDLY:
          // count down pre or frame delay
          cnt_reg <= SDS_FLD_W'(cnt_reg - 1'b1);
        SDS_POST:
          if (cnt_reg == '0)
          begin
            st_reg         <= SDS_XDLY;
            cnt_reg        <= xdly_f;
            spi_ssel_n_out <= 1'b1;
          end
          else
            cnt_reg <= SDS_FLD_W'(cnt_reg - 1'b1);
        SDS_XDLY:
          if (cnt_reg != '0)
            cnt_reg <= SDS_FLD_W'(cnt_reg - 1'b1);
          else if (hold_full_reg)
          begin
            st_reg         <= SDS_LEAD;
            spi_ssel_n_out <= 1'b0;
          end
          else
            st_reg <= SDS_IDLE;
        default:
          st_reg <= SDS_IDLE;
      endcase
    end
  end

  // master clock: high in the second half of each frame period
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      spi_sck_out <= 1'b0;
    else if ((st_reg == SDS_FRAME) && half)
      spi_sck_out <= 1'b1;
    else if (tick || !mst)
      spi_sck_out <= 1'b0;
  end

  // stall while waiting for data or receive space
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      stall_reg <= 1'b0;
    else
      stall_reg <= (st_reg == SDS_STALL);
  end

  // ----------------------------------------------------------------
  // slave engine
  // ----------------------------------------------------------------
  // overrun discards incoming character, buffer kept
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      slv_bit_reg <= '0;
      disc_reg    <= 1'b0;
      slv_tx_reg  <= '0;
    end
    else if (!slv_act)
      slv_bit_reg <= '0;
    else
    begin
      if (rise)
        slv_bit_reg <= 3'(slv_bit_reg + 1'b1);
      if (first)
      begin
        disc_reg   <= rx_full_reg;
        // nothing to send shifts out zeros
        slv_tx_reg <= hold_full_reg ? {hold_reg[SDS_DATA_W-2:0], 1'b0} : '0;
      end
      else if (fall)
        slv_tx_reg <= {slv_tx_reg[SDS_DATA_W-2:0], 1'b0};
    end
  end

  // edge history for sck and the select view
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sck_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
    end
    else
    begin
      sck_prev_reg <= sck_s;
      sel_prev_reg <= sel_now;
    end
  end

  // serial data out and drive enables for both modes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
      spi_mst_oe <= 1'b0;
    end
    else
    begin
      spi_mst_oe <= mst;
      spi_sdo_oe <= mst || slv_act;
      if (mst_start)
        spi_sdo <= hold_reg[SDS_DATA_W-1];
      else if ((st_reg == SDS_FRAME) && tick && (bit_reg != SDS_LAST_BIT))
        spi_sdo <= tx_sh_reg[SDS_DATA_W-2];
      else if (slv_act && fall)
        spi_sdo <= (slv_bit_reg == 3'h0) ? (hold_full_reg && hold_reg[SDS_DATA_W-1])
                                          : slv_tx_reg[SDS_DATA_W-1];
      else if (slv_act && (slv_bit_reg == 3'h0) && !sck_s)
        spi_sdo <= hold_full_reg && hold_reg[SDS_DATA_W-1];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_master_only: assert property (!mst |=> st_reg == SDS_IDLE)
    else $error("sequencer active outside master mode");
  a_pre_load: assert property ((st_reg == SDS_LEAD) && tick && (pre_f != 0) && !mst_start
    |=> (st_reg == SDS_PRE) && (cnt_reg == $past(pre_f) - 1))
    else $error("pre-delay count wrong");
  a_lead_period: assert property ($fell(spi_ssel_n_out) |-> st_reg == SDS_LEAD)
    else $error("select asserted without lead period");
  a_post_load: assert property (mst_done && eot_reg && (post_f != 0)
    |=> (st_reg == SDS_POST) && !spi_ssel_n_out)
    else $error("post-delay skipped");
  a_frame_gap: assert property (mst_done && !eot_reg && (fdly_f != 0)
    |=> (st_reg == SDS_FDLY) && (cnt_reg == $past(fdly_f) - 1))
    else $error("frame delay not applied");
  a_xfer_gap: assert property ($rose(spi_ssel_n_out) && mst
    |-> (st_reg == SDS_XDLY) && (cnt_reg == xdly_f))
    else $error("transfer delay not loaded");
  a_w1c_keep: assert property (wr_stat && !bus_wdata[SDS_ST_OVR] && sticky_reg[0]
    |=> sticky_reg[0])
    else $error("overrun cleared by zero write");
  a_rx_clear: assert property (rd_rx && !rx_load && en |=> !rx_full_reg)
    else $error("rx ready not cleared by read");
  a_tx_write: assert property (wr_tx && en |=> hold_full_reg ##0 !stat_v[SDS_ST_TX])
    else $error("tx ready not cleared on write");
  a_ovr_slave: assert property ($rose(sticky_reg[0]) |-> !$past(mst))
    else $error("overrun flagged in master mode");
  a_undr_set: assert property (undr_set |=> sticky_reg[1])
    else $error("underrun not flagged");
  a_ssa_set: assert property (ssa_set |=> sticky_reg[2])
    else $error("select assert not flagged");
  a_ssd_set: assert property (ssd_set |=> sticky_reg[3])
    else $error("select deassert not flagged");
  a_stall_flag: assert property ((st_reg == SDS_STALL) |=> stall_reg)
    else $error("stall flag missing");
  a_xdly_desel: assert property ((st_reg == SDS_XDLY) |-> spi_ssel_n_out)
    else $error("transfer delay with select asserted");

  c_master_xfer: cover property (mst_done && eot_reg);
  c_frame_delay: cover property ((st_reg == SDS_FDLY) ##1 (st_reg == SDS_FRAME));
  c_slave_ovr:   cover property (ovr_set);
  c_slave_undr:  cover property (undr_set);
endmodule // sds_spi_core

// ---- src/sds_sync.sv ----
// two-flop synchroniser for pin inputs
module sds_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_reg <= RST;
      q        <= RST;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // sds_sync

// ---- src/sds_tick.sv ----
// free-running spi clock period divider: period start and mid-period strobes
module sds_tick #(
  parameter int DIV = 16
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick,
  output logic      half
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_reg;

  // wraps every DIV cycles so all delays stay in whole periods
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt_reg <= '0;
    else if (cnt_reg == CW'(DIV - 1))
      cnt_reg <= '0;
    else
      cnt_reg <= CW'(cnt_reg + 1'b1);
  end

  assign tick = (cnt_reg == '0);
  assign half = (cnt_reg == CW'(DIV / 2));
endmodule // sds_tick
